// file: rtl/clock_loop_pkg.sv
// Contract
// - The instruction rate is the selected oscillator tick rate divided by two.
// - In the multiplied clock mode the oscillator ticks are the multiplier output ticks.
// - The reference input is divided by the prescale ratio, the prescaler field plus two.
// - The multiplied clock is divided by the postscale ratio, two times the postscaler field plus one.
// - Multiplier output rate is reference rate times feedback ratio over both scale ratios.
// - The internal oscillator rate before postscaling is reference rate times feedback ratio over the prescale ratio.
package clock_loop_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          ADR_W            = 8;
    localparam logic [7:0]  OFS_FEEDBACK     = 8'h00;
    localparam logic [7:0]  OFS_DISABLE      = 8'h04;
    localparam logic [7:0]  OFS_SCALER       = 8'h08;
    localparam logic [7:0]  OFS_STATUS       = 8'h0C;

    // ------------------------------------------------------------------
    // Field layouts and reset values
    // ------------------------------------------------------------------
    localparam int          FBD_W            = 9;
    localparam logic [8:0]  FBD_RESET        = 9'h030;
    localparam int          PRE_W            = 5;
    localparam int          PRE_LSB          = 0;
    localparam int          POST_W           = 2;
    localparam int          POST_LSB         = 6;
    localparam int          MODE_BIT         = 8;
    localparam logic [4:0]  PRE_RESET        = 5'h00;
    localparam logic [1:0]  POST_RESET       = 2'h0;
    localparam logic        MODE_RESET       = 1'b0;
    localparam int          DMA_BIT          = 4;
    localparam int          PTG_BIT          = 3;
    localparam logic        DISABLE_RESET    = 1'b0;
    localparam int          DMA_CHANNELS     = 4;

    // ------------------------------------------------------------------
    // Ratio widths, status layout, fixed counts
    // ------------------------------------------------------------------
    localparam int          M_W              = 10;
    localparam int          N1_W             = 6;
    localparam int          N2_W             = 4;
    localparam logic [1:0]  INSTR_DIVIDE     = 2'h2;
    localparam int          CREDIT_W         = 12;
    localparam int          ST_M_LSB         = 0;
    localparam int          ST_N1_LSB        = 10;
    localparam int          ST_N2_LSB        = 16;
    localparam int          ST_OVF_BIT       = 20;

    function automatic logic [M_W-1:0] loop_multiplier(input logic [FBD_W-1:0] code);
        return M_W'(code) + M_W'(2);
    endfunction

    function automatic logic [N1_W-1:0] prescale_ratio(input logic [PRE_W-1:0] code);
        return N1_W'(code) + N1_W'(2);
    endfunction

    function automatic logic [N2_W-1:0] postscale_ratio(input logic [POST_W-1:0] code);
        return N2_W'({code, 1'b0}) + N2_W'(2);
    endfunction

endpackage

// file: rtl/pin_sync.sv
module pin_sync
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    output logic      level_o
);

    logic stage1;
    logic stage2;
    logic stage3;

    // The level moves only when the last two stages agree, so a glitch
    // caught by one stage never reaches the edge detector downstream.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stage1  <= 1'b0;
            stage2  <= 1'b0;
            stage3  <= 1'b0;
            level_o <= 1'b0;
        end
        else
        begin
            stage1 <= pin_i;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3)
                level_o <= stage3;
        end
    end

endmodule

// file: rtl/tick_divider.sv
module tick_divider
#(
    parameter int W = 6
)
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         tick_i,
    input  wire logic [W-1:0] ratio_i,
    output logic              tick_o
);

    logic [W-1:0] count;
    wire  [W-1:0] count_plus = count + W'(1);
    wire          wrap       = count_plus >= ratio_i;

    // Comparing with >= lets a ratio lowered mid-count wrap at once
    // instead of running the counter round its full range.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            count  <= '0;
            tick_o <= 1'b0;
        end
        else
        begin
            tick_o <= tick_i & wrap;
            if (tick_i)
                count <= wrap ? '0 : count_plus;
        end
    end

endmodule

// file: rtl/clock_loop_ctrl.sv
// Added by the designer: the Wishbone slave port and the register addresses.
module clock_loop_ctrl
(
    input  wire logic                               clk_i,
    input  wire logic                               rst_i,
    input  wire logic                               cyc_i,
    input  wire logic                               stb_i,
    input  wire logic                               we_i,
    input  wire logic [clock_loop_pkg::ADR_W-1:0]   adr_i,
    input  wire logic [3:0]                         sel_i,
    input  wire logic [31:0]                        dat_i,
    output logic      [31:0]                        dat_o,
    output logic                                    ack_o,
    input  wire logic                               ref_pin_i,
    output logic                                    osc_tick_o,
    output logic                                    instr_tick_o,
    output logic                                    vco_tick_o,
    output logic      [clock_loop_pkg::DMA_CHANNELS-1:0] dma_disable_o,
    output logic                                    pattern_trigger_disable_o
);

    import clock_loop_pkg::*;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Power-on values come from the package, so the reset ratios are in
    // force before software writes anything.
    logic [FBD_W-1:0]    feedback_divisor_field;
    logic [PRE_W-1:0]    input_prescaler_field;
    logic [POST_W-1:0]   output_postscaler_field;
    logic                multiplied_mode;
    logic                dma_group_disable;
    logic                pattern_trigger_disable;
    logic                credit_overflow;
    logic [CREDIT_W-1:0] credits;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // A request is taken only while no answer stands, so a master that
    // holds its strobe through the ack cycle is never served twice.
    // Unmapped offsets are acknowledged as well and read as zero, so a
    // stray access cannot hang the bus.
    wire req      = cyc_i & stb_i & ~ack_o;
    wire wr       = req & we_i;
    wire wr_lo    = wr & sel_i[0];
    wire wr_hi    = wr & sel_i[1];
    wire wr_b2    = wr & sel_i[2];
    wire hit_fbd  = adr_i == OFS_FEEDBACK;
    wire hit_dis  = adr_i == OFS_DISABLE;
    wire hit_scl  = adr_i == OFS_SCALER;
    wire hit_sts  = adr_i == OFS_STATUS;

    // ------------------------------------------------------------------
    // Ratios
    // ------------------------------------------------------------------
    // The ratios are formed once and shared by the dividers and the status
    // read-back, so software reads exactly what the hardware divides by.
    wire [M_W-1:0]  mult_ratio = loop_multiplier(feedback_divisor_field);
    wire [N1_W-1:0] pre_ratio  = prescale_ratio(input_prescaler_field);
    wire [N2_W-1:0] post_ratio = postscale_ratio(output_postscaler_field);

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Every register except status sits in the low half-word, and status ends at bit 20;
    // the bits above them and all unimplemented positions are tied to zero here, so no
    // write path can ever make them read back as anything else.
    wire [31:0] rd_fbd = {23'h000000,
                          feedback_divisor_field};
    wire [31:0] rd_dis = {27'h0000000,
                          dma_group_disable,
                          pattern_trigger_disable,
                          3'h0};
    // Scaler control: prescaler in bits 4:0, bit 5 reserved, postscaler in
    // bits 7:6, clock mode in bit 8.
    wire [31:0] rd_scl = {23'h000000,
                          multiplied_mode,
                          output_postscaler_field,
                          1'b0,
                          input_prescaler_field};
    // Status: the three ratios as the dividers see them, then the sticky
    // overflow flag in bit 20, so software can check its arithmetic.
    wire [31:0] rd_sts = {11'h000,
                          credit_overflow,
                          post_ratio,
                          pre_ratio,
                          mult_ratio};
    wire [31:0] rd_mux = hit_fbd ? rd_fbd :
                         hit_dis ? rd_dis :
                         hit_scl ? rd_scl :
                         hit_sts ? rd_sts : 32'h00000000;

    // Read data is driven only in the ack cycle and is zero otherwise,
    // which lets a bus fabric merge several slaves with a plain OR.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end
        else
        begin
            ack_o <= req;
            dat_o <= req ? rd_mux : 32'h00000000;
        end
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // Each register changes only at the edge that takes the request, and
    // every byte lane gates its own field.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            feedback_divisor_field <= FBD_RESET;
        end
        else if (hit_fbd)
        begin
            if (wr_lo)
            begin
                feedback_divisor_field[7:0] <= dat_i[7:0];
            end
            // Bit 8 sits in the second byte lane, so a write to the low
            // lane alone leaves the top of the divisor as it was.
            if (wr_hi)
            begin
                feedback_divisor_field[8] <= dat_i[8];
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dma_group_disable       <= DISABLE_RESET;
            pattern_trigger_disable <= DISABLE_RESET;
        end
        // Both disable bits are in the low byte lane; no other lane holds state.
        else if (hit_dis && wr_lo)
        begin
            dma_group_disable       <= dat_i[DMA_BIT];
            pattern_trigger_disable <= dat_i[PTG_BIT];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            input_prescaler_field   <= PRE_RESET;
            output_postscaler_field <= POST_RESET;
            multiplied_mode         <= MODE_RESET;
        end
        else if (hit_scl)
        begin
            if (wr_lo)
            begin
                input_prescaler_field   <= dat_i[PRE_LSB +: PRE_W];
                output_postscaler_field <= dat_i[POST_LSB +: POST_W];
            end
            if (wr_hi)
            begin
                multiplied_mode <= dat_i[MODE_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // Reference input and prescaler
    // ------------------------------------------------------------------
    logic ref_level;
    logic ref_level_q;
    logic ref_tick;
    logic pre_tick;

    // The reference is asynchronous to the system clock, so it passes the
    // three-stage filter before any of its edges is counted.
    pin_sync u_ref_sync
    (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (ref_pin_i),
        .level_o (ref_level)
    );

    // The edge flop resets to the idle level of the pin, so the release
    // of reset never shows a false rising edge.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ref_level_q <= 1'b0;
            ref_tick    <= 1'b0;
        end
        else
        begin
            ref_level_q <= ref_level;
            ref_tick    <= ref_level & ~ref_level_q;
        end
    end

    // Only every prescale-ratio-th reference edge reaches the multiplier.
    tick_divider #(.W(N1_W)) u_prescaler
    (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .tick_i  (ref_tick),
        .ratio_i (pre_ratio),
        .tick_o  (pre_tick)
    );

    // ------------------------------------------------------------------
    // Feedback multiplier
    // ------------------------------------------------------------------
    // Each prescaled reference tick grants mult_ratio oscillator ticks,
    // paid out one per clock. The oscillator tick rate is thus exactly
    // the reference rate times the feedback ratio over the prescale
    // ratio, as long as the product stays below the system clock rate.
    // Beyond that the credit store saturates and the overflow flag
    // tells software that the programmed ratio cannot be honoured.
    wire                credit_spend = credits != '0;
    wire [CREDIT_W-1:0] credit_after = credits - CREDIT_W'(credit_spend);
    wire [CREDIT_W:0]   credit_sum   = {1'b0, credit_after} + (CREDIT_W+1)'(mult_ratio);
    wire                credit_full  = pre_tick & credit_sum[CREDIT_W];
    // Status is read-only except bit 20, which a one in the third lane clears.
    wire                ovf_clear    = hit_sts & wr_b2 & dat_i[ST_OVF_BIT];
    wire [CREDIT_W-1:0] next_credits = ~pre_tick   ? credit_after :
                                       credit_full ? {CREDIT_W{1'b1}} :
                                                     credit_sum[CREDIT_W-1:0];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            credits         <= '0;
            vco_tick_o      <= 1'b0;
            credit_overflow <= 1'b0;
        end
        else
        begin
            credits         <= next_credits;
            vco_tick_o      <= credit_spend;
            // Set wins over a clear in the same cycle, so no overflow is lost.
            credit_overflow <= credit_full |
                               (credit_overflow & ~ovf_clear);
        end
    end

    // ------------------------------------------------------------------
    // Postscaler, clock selection, instruction rate
    // ------------------------------------------------------------------
    logic pll_tick;

    // The postscaler counts internal oscillator ticks, not system clocks,
    // so its output rate follows the programmed ratio exactly.
    tick_divider #(.W(N2_W)) u_postscaler
    (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .tick_i  (vco_tick_o),
        .ratio_i (post_ratio),
        .tick_o  (pll_tick)
    );

    // Registering the selected tick keeps the output straight from a flop
    // and costs the same one cycle of latency in both modes.
    wire next_osc_tick = multiplied_mode ? pll_tick : ref_tick;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            osc_tick_o <= 1'b0;
        end
        else
        begin
            osc_tick_o <= next_osc_tick;
        end
    end

    // A two-count divider halves the oscillator ticks; the first
    // instruction tick follows the second oscillator tick.
    tick_divider #(.W(2)) u_instr_divider
    (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .tick_i  (osc_tick_o),
        .ratio_i (INSTR_DIVIDE),
        .tick_o  (instr_tick_o)
    );

    // ------------------------------------------------------------------
    // Module gating
    // ------------------------------------------------------------------
    // One stored bit fans out to all four channels, so they never disagree.
    assign dma_disable_o             = {DMA_CHANNELS{dma_group_disable}};
    assign pattern_trigger_disable_o = pattern_trigger_disable;

endmodule

// file: test/clock_loop_checker.sv
module clock_loop_checker
(
    input  wire logic                                    clk_i,
    input  wire logic                                    rst_i,
    input  wire logic                                    cyc_i,
    input  wire logic                                    stb_i,
    input  wire logic                                    we_i,
    input  wire logic [clock_loop_pkg::ADR_W-1:0]        adr_i,
    input  wire logic [3:0]                              sel_i,
    input  wire logic [31:0]                             dat_i,
    input  wire logic [31:0]                             dat_o,
    input  wire logic                                    ack_o,
    input  wire logic                                    ref_pin_i,
    input  wire logic                                    osc_tick_o,
    input  wire logic                                    instr_tick_o,
    input  wire logic                                    vco_tick_o,
    input  wire logic [clock_loop_pkg::DMA_CHANNELS-1:0] dma_disable_o,
    input  wire logic                                    pattern_trigger_disable_o
);
    import clock_loop_pkg::*;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Oscillator ticks not yet paid for by an instruction tick; a halving divider keeps it within 0..2.
    logic       req;
    logic [1:0] osc_lead;
    assign req = cyc_i && stb_i && !ack_o;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            osc_lead <= 2'h0;
        else
            osc_lead <= osc_lead + 2'(osc_tick_o) - {instr_tick_o, 1'b0};
    end

    chk_ack_latency: assert property (req |=> ack_o)
        else $error("ack missing one cycle after request");
    chk_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property (ack_o |-> $past(req))
        else $error("ack without request");
    chk_data_idle: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack cycle");
    chk_fbd_unused: assert property (ack_o && !we_i && adr_i == OFS_FEEDBACK |-> dat_o[31:9] == 23'h0)
        else $error("feedback divisor upper bits not zero");
    chk_pmd_unused: assert property (ack_o && !we_i && adr_i == OFS_DISABLE |-> (dat_o & 32'hFFFFFFE7) == 32'h0)
        else $error("module disable unused bits not zero");
    chk_dma_write: assert property (req && we_i && sel_i[0] && adr_i == OFS_DISABLE |->
        ##2 dma_disable_o == {DMA_CHANNELS{$past(dat_i[DMA_BIT], 2)}})
        else $error("dma group disable does not follow bit 4");
    chk_ptg_write: assert property (req && we_i && sel_i[0] && adr_i == OFS_DISABLE |->
        ##2 pattern_trigger_disable_o == $past(dat_i[PTG_BIT], 2))
        else $error("pattern trigger disable does not follow bit 3");
    chk_instr_half: assert property (osc_lead <= 2'h2)
        else $error("instruction ticks not every second oscillator tick");

    cover property (req && we_i);
    cover property (instr_tick_o);
    cover property (dma_disable_o == 4'hF && pattern_trigger_disable_o);
endmodule

bind clock_loop_ctrl clock_loop_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .ref_pin_i(ref_pin_i), .osc_tick_o(osc_tick_o), .instr_tick_o(instr_tick_o), .vco_tick_o(vco_tick_o),
    .dma_disable_o(dma_disable_o), .pattern_trigger_disable_o(pattern_trigger_disable_o));

// file: test/loop_divider_and_module_gating_tb.sv
module loop_divider_and_module_gating_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import clock_loop_pkg::*;

    logic                    clk_i, rst_i, cyc_i, stb_i, we_i, ref_pin_i, ack_o;
    logic                    osc_tick_o, instr_tick_o, vco_tick_o, pattern_trigger_disable_o;
    logic [ADR_W-1:0]        adr_i;
    logic [3:0]              sel_i;
    logic [31:0]             dat_i, dat_o, rd;
    logic [DMA_CHANNELS-1:0] dma_disable_o;
    int                      error_cnt = 0, num_checks = 0, n_vco = 0, n_osc = 0, n_instr = 0;

    clock_loop_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ref_pin_i(ref_pin_i),
        .osc_tick_o(osc_tick_o), .instr_tick_o(instr_tick_o), .vco_tick_o(vco_tick_o),
        .dma_disable_o(dma_disable_o), .pattern_trigger_disable_o(pattern_trigger_disable_o));

    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    always @(posedge clk_i)
    begin
        n_vco += int'(vco_tick_o);
        n_osc += int'(osc_tick_o);
        n_instr += int'(instr_tick_o);
    end

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        sel_i <= 4'hF;
        adr_i <= a;
        dat_i <= d;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            error_cnt++;
            conclude();
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Reference edges are spaced far below the clock rate so every grant drains between them.
    task automatic pulses(input int k);
        repeat (k)
        begin
            @(posedge clk_i);
            ref_pin_i <= 1'b1;
            repeat (20) @(posedge clk_i);
            ref_pin_i <= 1'b0;
            repeat (20) @(posedge clk_i);
        end
        repeat (60) @(posedge clk_i);
    endtask

    task automatic t_regs();
        logic [31:0] v[4] = '{32'hFFFFFFFF, 32'h10, 32'h08, 32'h0};
        wb(1'b0, OFS_FEEDBACK, 32'h0, rd);
        chk("feedback reset", 32'h30, rd);
        wb(1'b0, OFS_DISABLE, 32'h0, rd);
        chk("disable reset", 32'h0, rd);
        wb(1'b1, OFS_FEEDBACK, 32'hFFFFFFFF, rd);
        wb(1'b0, OFS_FEEDBACK, 32'h0, rd);
        chk("feedback all ones", 32'h1FF, rd);
        wb(1'b0, OFS_STATUS, 32'h0, rd);
        chk("multiplier 513", 32'd513, {22'h0, rd[9:0]});
        foreach (v[i])
        begin
            wb(1'b1, OFS_DISABLE, v[i], rd);
            wb(1'b0, OFS_DISABLE, 32'h0, rd);
            chk("disable readback", v[i] & 32'h18, rd);
            chk("dma group", {28'h0, {4{v[i][4]}}}, {28'h0, dma_disable_o});
            chk("pattern trigger", {31'h0, v[i][3]}, {31'h0, pattern_trigger_disable_o});
        end
        wb(1'b1, 8'h40, 32'h5A, rd);
        wb(1'b0, 8'h40, 32'h0, rd);
        chk("unmapped read", 32'h0, rd);
        $display("Register test done");
    endtask

    task automatic t_rates();
        int m = 2 + 2, n1 = 1 + 2, n2 = 2 * (1 + 1), v0, o0, i0;
        wb(1'b1, OFS_FEEDBACK, 32'h2, rd);
        wb(1'b1, OFS_SCALER, 32'h141, rd);
        wb(1'b0, OFS_STATUS, 32'h0, rd);
        chk("prescale ratio", 32'(n1), {26'h0, rd[15:10]});
        v0 = n_vco;
        o0 = n_osc;
        i0 = n_instr;
        pulses(6);
        chk("vco ticks", 32'(6 / n1 * m), 32'(n_vco - v0));
        chk("multiplied osc ticks", 32'(6 / n1 * m / n2), 32'(n_osc - o0));
        chk("instr ticks", 32'(6 / n1 * m / n2 / 2), 32'(n_instr - i0));
        wb(1'b1, OFS_SCALER, 32'h041, rd);
        v0 = n_vco;
        o0 = n_osc;
        i0 = n_instr;
        pulses(6);
        chk("vco ticks ref mode", 32'(6 / n1 * m), 32'(n_vco - v0));
        chk("ref osc ticks", 32'd6, 32'(n_osc - o0));
        chk("ref instr ticks", 32'd3, 32'(n_instr - i0));
        $display("Rate test done");
    endtask

    // Fast reference edges with the largest multiplier outrun the drain, so the store saturates.
    task automatic t_overflow();
        wb(1'b1, OFS_FEEDBACK, 32'h1FF, rd);
        wb(1'b1, OFS_SCALER, 32'h000, rd);
        repeat (24)
        begin
            ref_pin_i <= 1'b1;
            repeat (4) @(posedge clk_i);
            ref_pin_i <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
        wb(1'b0, OFS_STATUS, 32'h0, rd);
        chk("credit overflow set", 32'h1, {31'h0, rd[ST_OVF_BIT]});
        wb(1'b1, OFS_STATUS, 32'h00100000, rd);
        wb(1'b0, OFS_STATUS, 32'h0, rd);
        chk("credit overflow cleared", 32'h0, {31'h0, rd[ST_OVF_BIT]});
        repeat (4200) @(posedge clk_i);
        $display("Overflow test done");
    endtask

    initial
    begin
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = '0;
        sel_i = 4'hF;
        dat_i = '0;
        ref_pin_i = 1'b0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_rates();
        t_overflow();
        conclude();
    end
endmodule
